// ---- inc/spp_pkg.sv ----
package spp_pkg;
  localparam int DATA_W = 32;
  localparam int GATE_HOLD = 1024;
  localparam logic [1:0] WSZ_16 = 2'h0;
  localparam logic [1:0] WSZ_24 = 2'h1;
  localparam logic [1:0] WSZ_32 = 2'h2;
  localparam int GATE_LSB_16 = 16;
  localparam int GATE_LSB_24 = 24;
  localparam logic [6:0] VOL_MUTE = 7'h7f;
  localparam logic [6:0] VOL_RESET = 7'h00;
  localparam logic [3:0] BOOST_RESET = 4'h0;
  localparam logic [3:0] PEAK_RESET = 4'h0;
  localparam logic [3:0] PEAK_MAX_CODE = 4'he;
  localparam logic SAFE_RESET = 1'b1;
  localparam int SAFE_SHIFT = 3;
  localparam int DC_SHIFT = 10;
  localparam int RAMP_STEP_LOG = 4;
  typedef struct packed {
    logic gate_enable;
    logic [4:0] gate_close_level;
    logic [4:0] gate_open_level;
    logic [1:0] serial_word_size;
    logic tone_select;
    logic dither_enable;
    logic polarity_flip;
    logic dc_removal_enable;
    logic [6:0] volume_attenuation;
    logic ramp_up_control;
    logic ramp_down_control;
    logic [3:0] digital_boost;
    logic loopback_tap_enable;
    logic protect_attenuation_enable;
    logic [3:0] peak_output_scaling;
    logic active;
  } spp_cfg_s;
endpackage

// ---- logic/spp_speaker_path.sv ----
module spp_speaker_path #(
  parameter int GATE_COUNT = 1024
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic link_rst,
  input wire logic [31:0] link_sample,
  input wire logic link_valid,
  input wire logic [31:0] tone_sample,
  input wire spp_pkg::spp_cfg_s cfg,
  input wire logic [15:0] sense_i_in,
  input wire logic [15:0] sense_v_in,
  output logic [31:0] dac_out,
  output logic dac_valid,
  output logic [3:0] peak_scale_out,
  output logic [15:0] sense_i_out,
  output logic [15:0] sense_v_out,
  output logic low_power,
  output logic gate_closed,
  output logic [31:0] tap_out,
  output logic tap_valid
);
  import spp_pkg::*;

  // link domain: capture word, toggle event
  logic [31:0] lk_word;
  logic lk_tog;
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      lk_word <= '0;
      lk_tog <= 1'b0;
    end else if (link_valid) begin
      lk_word <= link_sample;
      lk_tog <= ~lk_tog;
    end
  end

  // core domain toggle synchroniser; word stable while toggle settles
  logic tg_s1, tg_s2, tg_s3, tg_s4;
  logic [31:0] in_word;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tg_s1 <= 1'b0;
      tg_s2 <= 1'b0;
      tg_s3 <= 1'b0;
      tg_s4 <= 1'b0;
    end else begin
      tg_s1 <= lk_tog;
      tg_s2 <= tg_s1;
      tg_s3 <= tg_s2;
      tg_s4 <= tg_s3;
    end
  end
  // word captured once the toggle is settled, processed one cycle later
  wire word_evt = tg_s2 ^ tg_s3;
  wire smp_evt = tg_s3 ^ tg_s4;
  always_ff @(posedge core_clk) begin
    if (rst) in_word <= '0;
    else if (word_evt) in_word <= lk_word;
  end

  // align to msb regardless of word size; source select
  function automatic logic [31:0] align(input logic [31:0] w, input logic [1:0] sz);
    if (sz == WSZ_16) return {w[15:0], 16'h0000};
    if (sz == WSZ_24) return {w[23:0], 8'h00};
    return w;
  endfunction
  wire [31:0] link_al = align(in_word, cfg.serial_word_size);
  wire [31:0] src = cfg.tone_select ? tone_sample : link_al;

  // magnitude in gate lsb units, then active bit count
  wire signed [31:0] src_s = $signed(link_al);
  wire [31:0] mag = src_s[31] ? 32'(-src_s) : 32'(src_s);
  wire [23:0] mag_lsb = mag[31:8];
  function automatic logic [4:0] bitlen(input logic [23:0] v);
    logic [4:0] n;
    n = 5'h00;
    for (int k = 0; k < 24; k++) begin
      if (v[k]) n = 5'(k + 1);
    end
    return n;
  endfunction
  // 16-bit words keep lsb at bit 16 of the aligned word: 8 lsb-units below it
  wire [23:0] gate_mag = (cfg.serial_word_size == WSZ_16) ? {8'h00, mag_lsb[23:8]} : mag_lsb;
  wire [4:0] act_bits = bitlen(gate_mag);
  wire quiet = act_bits <= cfg.gate_close_level;
  wire loud = act_bits > cfg.gate_open_level;

  // gate state machine
  typedef enum logic [1:0] {G_OPEN = 2'b01, G_SHUT = 2'b10} spp_gate_e;
  spp_gate_e gst, next_gst;
  logic [10:0] qcnt, next_qcnt;
  wire gate_on = cfg.active & cfg.gate_enable;
  always_comb begin
    next_gst = gst;
    next_qcnt = qcnt;
    unique case (gst)
      G_OPEN: begin
        if (!gate_on) next_qcnt = '0;
        else if (smp_evt) begin
          if (!quiet) next_qcnt = '0;
          else if (qcnt >= 11'(GATE_COUNT)) next_gst = G_SHUT;
          else next_qcnt = qcnt + 11'h001;
        end
      end
      G_SHUT: begin
        // stays shut on disable until a loud sample
        if (smp_evt && loud) begin
          next_gst = G_OPEN;
          next_qcnt = '0;
        end
      end
      default: next_gst = G_OPEN;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      gst <= G_OPEN;
      qcnt <= '0;
    end else begin
      gst <= next_gst;
      qcnt <= next_qcnt;
    end
  end
  // unmute is decided combinationally from the same sample entering the pipe
  wire muted_now = (next_gst == G_SHUT);

  // dither lfsr
  logic [15:0] lfsr;
  always_ff @(posedge core_clk) begin
    if (rst) lfsr <= 16'hace1;
    else if (smp_evt) lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
  end

  // stage 1: dither, invert
  wire signed [31:0] s_in = $signed(src);
  wire signed [31:0] dith = cfg.dither_enable ? (lfsr[0] ? 32'sd256 : -32'sd256) : 32'sd0;
  wire signed [31:0] s_d = s_in + (dith >>> 1);
  wire signed [31:0] s_i = cfg.polarity_flip ? -s_d : s_d;

  // dc removal: y = x - avg, avg tracks slowly
  logic signed [47:0] dc_acc;
  wire signed [31:0] dc_est = 32'(dc_acc >>> 16);
  wire signed [31:0] s_hp = cfg.dc_removal_enable ? (s_i - dc_est) : s_i;
  always_ff @(posedge core_clk) begin
    if (rst) dc_acc <= '0;
    else if (smp_evt && cfg.dc_removal_enable) dc_acc <= dc_acc + (48'(s_hp) <<< (16 - DC_SHIFT));
  end

  // volume: 0.5dB steps; 12 steps is 6dB (shift), table for fractional part
  // unity is 17'h10000 so that 0dB passes samples unchanged
  function automatic logic [16:0] half_db(input logic [3:0] f);
    case (f)
      4'h0: return 17'h10000;
      4'h1: return 17'h0f1a1;
      4'h2: return 17'h0e42b;
      4'h3: return 17'h0d765;
      4'h4: return 17'h0cb59;
      4'h5: return 17'h0bff4;
      4'h6: return 17'h0b53b;
      4'h7: return 17'h0ab25;
      4'h8: return 17'h0a1a8;
      4'h9: return 17'h098bc;
      4'ha: return 17'h09055;
      4'hb: return 17'h0886b;
      default: return 17'h08000;
    endcase
  endfunction
  // ramp target and current attenuation in half-dB units
  logic [6:0] vol_cur;
  wire [6:0] vol_tgt = (!cfg.active || cfg.volume_attenuation == VOL_MUTE) ? VOL_MUTE : cfg.volume_attenuation;
  logic [RAMP_STEP_LOG-1:0] rdiv;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      vol_cur <= VOL_MUTE;
      rdiv <= '0;
    end else begin
      if (smp_evt) rdiv <= rdiv + 1'b1;
      // ramps one step per 16 samples when enabled, else jumps at once
      if (vol_cur > vol_tgt) begin
        if (!cfg.ramp_up_control) vol_cur <= vol_tgt;
        else if (smp_evt && rdiv == '0) vol_cur <= vol_cur - 7'h01;
      end else if (vol_cur < vol_tgt) begin
        if (!cfg.ramp_down_control) vol_cur <= vol_tgt;
        else if (smp_evt && rdiv == '0) vol_cur <= vol_cur + 7'h01;
      end
    end
  end
  wire [6:0] vq = vol_cur / 7'd12;
  wire [3:0] vr = 4'(vol_cur - 7'(vq * 7'd12));
  wire signed [48:0] v_mul = s_hp * $signed({1'b0, half_db(vr)});
  wire signed [31:0] s_vol = 32'((v_mul >>> 16) >>> vq);
  // boost: +0.5dB steps up to +6dB = 2 x table^-1; use 2*table(12-g)
  wire [3:0] bcode = (cfg.digital_boost > 4'hc) ? 4'hc : cfg.digital_boost;
  wire signed [48:0] b_mul = s_vol * $signed({1'b0, half_db(4'(4'hc - bcode))});
  wire signed [31:0] s_boost = (bcode == 4'h0) ? s_vol : 32'(b_mul >>> 15);
  // safe mode: 36 half-dB steps = 3 octaves exactly
  wire signed [31:0] s_safe = s_hp >>> SAFE_SHIFT;
  wire signed [31:0] s_fin = cfg.protect_attenuation_enable ? s_safe : s_boost;
  wire mute_all = muted_now || (!cfg.protect_attenuation_enable && vol_cur == VOL_MUTE);
  wire [31:0] out_w = mute_all ? 32'h0 : 32'(s_fin);

  // outputs, all registered
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dac_out <= '0;
      dac_valid <= 1'b0;
      tap_out <= '0;
      tap_valid <= 1'b0;
      peak_scale_out <= PEAK_RESET;
      sense_i_out <= '0;
      sense_v_out <= '0;
      low_power <= 1'b0;
      gate_closed <= 1'b0;
    end else begin
      dac_valid <= smp_evt;
      if (smp_evt) dac_out <= out_w;
      tap_valid <= smp_evt & cfg.loopback_tap_enable;
      if (smp_evt && cfg.loopback_tap_enable) tap_out <= out_w;
      peak_scale_out <= (cfg.peak_output_scaling > PEAK_MAX_CODE) ? PEAK_MAX_CODE : cfg.peak_output_scaling;
      sense_i_out <= (gst == G_SHUT) ? 16'h0000 : sense_i_in;
      sense_v_out <= (gst == G_SHUT) ? 16'h0000 : sense_v_in;
      low_power <= (gst == G_SHUT);
      gate_closed <= (gst == G_SHUT);
    end
  end
endmodule

// ---- verif/spp_link_src.sv ----
module spp_link_src (
  input wire logic link_clk,
  output logic [31:0] link_sample,
  output logic link_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    link_sample = 32'h0;
    link_valid = 1'b0;
  end
  // word is valid for one link cycle, then the line shows its inverse
  task automatic send(input logic [31:0] w);
    @(posedge link_clk);
    link_sample <= w;
    link_valid <= 1'b1;
    fork begin
      @(posedge link_clk);
      link_sample <= ~w;
      link_valid <= 1'b0;
    end join_none
  endtask
endmodule

// ---- verif/spp_speaker_path_sva.sv ----
module spp_speaker_path_sva #(
  parameter int GATE_COUNT = 1024
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire spp_pkg::spp_cfg_s cfg,
  input wire logic [31:0] dac_out,
  input wire logic dac_valid,
  input wire logic [3:0] peak_scale_out,
  input wire logic [15:0] sense_i_out,
  input wire logic [15:0] sense_v_out,
  input wire logic low_power,
  input wire logic gate_closed,
  input wire logic [31:0] tap_out,
  input wire logic tap_valid
);
  import spp_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence shut_two;
    gate_closed [*2];
  endsequence
  chk_sense_zero: assert property (shut_two |-> sense_i_out == 16'h0 && sense_v_out == 16'h0)
    else $error("sense data not zero while gate shut");
  chk_power_follows: assert property (low_power == gate_closed)
    else $error("low power differs from gate state");
  chk_shut_silent: assert property (gate_closed && dac_valid ##1 gate_closed |-> $past(dac_out) == 32'h0)
    else $error("sample passed a shut gate");
  chk_vol_mute: assert property (
    dac_valid && !cfg.protect_attenuation_enable && cfg.volume_attenuation == VOL_MUTE
    && $past(cfg.volume_attenuation, 4) == VOL_MUTE |-> dac_out == 32'h0)
    else $error("mute code let a sample through");
  chk_peak_clamp: assert property (
    !$past(rst) |-> peak_scale_out == ($past(cfg.peak_output_scaling) > PEAK_MAX_CODE
    ? PEAK_MAX_CODE : $past(cfg.peak_output_scaling)))
    else $error("peak scaling code wrong");
  chk_tap_copy: assert property (tap_valid |-> dac_valid && tap_out == dac_out)
    else $error("tap differs from output");
  chk_tap_gated: assert property (tap_valid |-> $past(cfg.loopback_tap_enable))
    else $error("tap pulse while disabled");
  chk_gate_cause: assert property ($rose(gate_closed) |-> $past(cfg.gate_enable && cfg.active))
    else $error("gate shut while not enabled");
endmodule

// ---- verif/spp_speaker_path_test.sv ----
module spp_speaker_path_test;
  timeunit 1ns;
  timeprecision 1ps;
  import spp_pkg::*;
  logic core_clk = 1'b0, link_clk = 1'b0, rst = 1'b1, link_rst = 1'b1;
  logic [31:0] link_sample, dac_out, tap_out, got, gtap, tone_sample = 32'h2000_0000;
  logic [15:0] sense_i_in = 16'h1234, sense_v_in = 16'h5678, sense_i_out, sense_v_out;
  logic [3:0] peak_scale_out;
  logic link_valid, dac_valid, low_power, gate_closed, tap_valid;
  spp_cfg_s cfg = '{protect_attenuation_enable: 1'b1, active: 1'b1, serial_word_size: WSZ_32, default: 0};
  int miscompares = 0, tests_run = 0, cycles = 0;
  always #4 core_clk = ~core_clk;
  initial begin
    #7;
    forever #24 link_clk = ~link_clk;
  end
  spp_link_src i_spp_link_src (.link_clk(link_clk), .link_sample(link_sample), .link_valid(link_valid));
  spp_speaker_path #(.GATE_COUNT(8)) i_spp_speaker_path (.core_clk(core_clk), .rst(rst), .link_clk(link_clk),
    .link_rst(link_rst), .link_sample(link_sample), .link_valid(link_valid), .tone_sample(tone_sample), .cfg(cfg),
    .sense_i_in(sense_i_in), .sense_v_in(sense_v_in), .dac_out(dac_out), .dac_valid(dac_valid),
    .peak_scale_out(peak_scale_out), .sense_i_out(sense_i_out), .sense_v_out(sense_v_out), .low_power(low_power),
    .gate_closed(gate_closed), .tap_out(tap_out), .tap_valid(tap_valid));
  task automatic complete_run();
    if (miscompares == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic set_cfg(input spp_cfg_s c);
    @(posedge core_clk);
    cfg <= c;
    @(posedge core_clk);
  endtask
  task automatic push(input logic [31:0] w);
    int n;
    n = 0;
    i_spp_link_src.send(w);
    while (dac_valid !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("answer", 32'h1, {31'h0, dac_valid});
    got = dac_out;
    gtap = tap_out;
    @(posedge core_clk);
    #1;
    @(posedge link_clk);
  endtask
  task automatic t_safe();
    spp_cfg_s c;
    c = cfg;
    c.volume_attenuation = VOL_MUTE;
    c.peak_output_scaling = 4'hf;
    set_cfg(c);
    push(32'h4000_0000);
    chk("safe out", 32'h0800_0000, got);
    chk("peak code", {28'h0, PEAK_MAX_CODE}, {28'h0, peak_scale_out});
  endtask
  task automatic t_path();
    spp_cfg_s c;
    c = cfg;
    c.protect_attenuation_enable = 1'b0;
    c.volume_attenuation = VOL_RESET;
    c.polarity_flip = 1'b1;
    set_cfg(c);
    push(32'h1000_0000);
    chk("inverted", 32'hf000_0000, got);
    c.polarity_flip = 1'b0;
    c.volume_attenuation = VOL_MUTE;
    set_cfg(c);
    push(32'h1000_0000);
    chk("muted", 32'h0, got);
    c.volume_attenuation = 7'h0c;
    set_cfg(c);
    push(32'h1000_0000);
    chk("minus 6dB", 32'h0800_0000, got);
    c.digital_boost = 4'hc;
    set_cfg(c);
    push(32'h1000_0000);
    chk("plus 6dB", 32'h1000_0000, got);
    c.digital_boost = BOOST_RESET;
    c.volume_attenuation = VOL_RESET;
    c.tone_select = 1'b1;
    c.loopback_tap_enable = 1'b1;
    set_cfg(c);
    push(32'h1234_5678);
    chk("tone", tone_sample, got);
    chk("tap", tone_sample, gtap);
  endtask
  task automatic t_gate();
    spp_cfg_s c;
    c = cfg;
    c.tone_select = 1'b0;
    c.loopback_tap_enable = 1'b0;
    c.serial_word_size = WSZ_16;
    c.gate_close_level = 5'h2;
    c.gate_open_level = 5'h4;
    c.gate_enable = 1'b1;
    set_cfg(c);
    for (int k = 1; k <= 10; k++) begin
      push(32'h0);
      chk("gate shut", {31'h0, k >= 9}, {31'h0, gate_closed});
    end
    chk("sense zero", 32'h0, {sense_i_out, sense_v_out});
    chk("idle", 32'h1, {31'h0, low_power});
    c.gate_enable = 1'b0;
    set_cfg(c);
    push(32'h0000_fffd);
    chk("held shut", 32'h1, {31'h0, gate_closed});
    push(32'h0000_000f);
    chk("edge quiet", 32'h1, {31'h0, gate_closed});
    push(32'h0000_001f);
    chk("reopened", 32'h0, {31'h0, gate_closed});
    chk("sense back", {sense_i_in, sense_v_in}, {sense_i_out, sense_v_out});
    repeat (10) push(32'h0);
    chk("gate off", 32'h0, {31'h0, gate_closed});
  endtask
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge link_clk);
    link_rst <= 1'b0;
    repeat (4) @(posedge link_clk);
    t_safe();
    t_path();
    t_gate();
    complete_run();
  end
endmodule
bind spp_speaker_path spp_speaker_path_sva #(.GATE_COUNT(GATE_COUNT)) i_spp_speaker_path_sva (.core_clk(core_clk),
  .rst(rst), .cfg(cfg), .dac_out(dac_out), .dac_valid(dac_valid), .peak_scale_out(peak_scale_out),
  .sense_i_out(sense_i_out), .sense_v_out(sense_v_out), .low_power(low_power), .gate_closed(gate_closed),
  .tap_out(tap_out), .tap_valid(tap_valid));
